// ==== hw/dual_timer_counter.sv ====
/*
  Two timer/counter units with 13-bit, 16-bit, 8-bit auto-reload and split/halt modes.
  Assumes software writes control, mode and count bytes through the write ports, and that
  the interrupt controller pulses the service inputs when it vectors.
  Count and gating pins are asynchronous and pass two flops before any logic reads them.
  Software keeps the run-bit rules when presetting counts or changing modes.
*/
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter
  import dual_timer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic double_speed_mode,
  input wire logic unit0_clock_double_select,
  input wire logic unit1_clock_double_select,
  input wire logic count_pin_0,
  input wire logic count_pin_1,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic mode_wr,
  input wire logic [7:0] mode_wdata,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [3:0] count_wr,
  input wire logic [7:0] count_wdata,
  input wire logic unit0_serviced,
  input wire logic unit1_serviced,
  output logic [7:0] timer_mode_register,
  output logic [7:0] timer_control_register,
  output logic [7:0] unit0_low_byte,
  output logic [7:0] unit0_high_byte,
  output logic [7:0] unit1_low_byte,
  output logic [7:0] unit1_high_byte,
  output logic unit0_irq,
  output logic unit1_irq,
  output logic baud_tick
);
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic [7:0] l0;
    logic [7:0] h0;
    logic [7:0] l1;
    logic [7:0] h1;
    // stages 1:0 follow the count pin, stages 3:2 the gating pin
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic prev0;
    logic prev1;
    logic baud;
  } state_t;
  state_t st;
  state_t next_st;
  logic tick0;
  logic tick1;

  //////////////////////////////////////////////////////////////////////
  timer_clock_gen u_clk0 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clock_double_select(unit0_clock_double_select),
    .double_speed_mode(double_speed_mode),
    .per_tick(tick0)
  );
  timer_clock_gen u_clk1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clock_double_select(unit1_clock_double_select),
    .double_speed_mode(double_speed_mode),
    .per_tick(tick1)
  );

  //////////////////////////////////////////////////////////////////////
  // one unit's increment enable from its nibble, run bit and inputs
  function automatic logic unit_inc(input logic [3:0] nib, input logic run, input logic tick,
                                    input logic pin, input logic prev, input logic irq);
    logic gate_ok;
    logic src;
    gate_ok = run && (!nib[MODE_GATE_POS] || irq);
    src = nib[MODE_SRC_POS] ? (prev && !pin) : 1'b1;
    return tick && gate_ok && src;
  endfunction

  // 8-bit increment; bit 8 is the rollover from all ones
  function automatic logic [8:0] inc8(input logic [7:0] v);
    logic [8:0] r;
    r = {1'b0, v} + 9'h001;
    return r;
  endfunction

  // mode field of one unit's nibble
  function automatic timer_mode_t mode_of(input logic [3:0] nib);
    return timer_mode_t'(nib[MODE_HI_POS:MODE_LO_POS]);
  endfunction

  // overflow flag: a rollover in the same cycle beats the service clear
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    logic r;
    r = cur;
    if (clr) begin
      r = 1'b0;
    end
    if (set) begin
      r = 1'b1;
    end
    return r;
  endfunction

  // advance one unit; returns overflow in bit 16
  function automatic logic [16:0] unit_step(input logic [1:0] m, input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (timer_mode_t'(m))
      MODE_13BIT: begin
        if (lo[4:0] == PRESCALE_MAX) begin
          r[7:0] = {lo[7:5], 5'h00};
          r[15:8] = hi + 8'h01;
          r[16] = (hi == 8'hFF);
        end else begin
          r[7:0] = {lo[7:5], lo[4:0] + 5'h01};
        end
      end
      MODE_16BIT: begin
        r = {1'b0, hi, lo} + 17'h00001;
      end
      MODE_AUTO_RELOAD: begin
        if (lo == 8'hFF) begin
          r[7:0] = hi;
          r[16] = 1'b1;
        end else begin
          r[7:0] = lo + 8'h01;
        end
      end
      default: begin
        r = {1'b0, hi, lo};
      end
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [3:0] nib0;
    logic [3:0] nib1;
    logic in0;
    logic in1;
    logic inh;
    logic ovf0;
    logic ovf1;
    logic [16:0] s;
    logic [8:0] b;
    logic split0;
    logic hold1;
    logic run0;
    logic run1;
    logic pin0;
    logic pin1;
    logic unit0_gating_bit;
    logic unit1_gating_bit;
    nib0 = st.mode[3:0];
    nib1 = st.mode[7:4];
    in0 = 1'b0;
    in1 = 1'b0;
    inh = 1'b0;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    s = 17'h00000;
    b = 9'h000;
    split0 = (mode_of(nib0) == MODE_SPLIT_HALT);
    hold1 = (mode_of(nib1) == MODE_SPLIT_HALT);
    run0 = st.ctrl[CTRL_U0_RUN_POS];
    run1 = st.ctrl[CTRL_U1_RUN_POS];
    // logic reads only the second flop of each pin
    pin0 = st.sync_a[1];
    pin1 = st.sync_b[1];
    unit0_gating_bit = st.sync_a[3];
    unit1_gating_bit = st.sync_b[3];
    next_st = st;
    next_st.sync_a = {st.sync_a[2], ext_irq_pin_a, st.sync_a[0], count_pin_0};
    next_st.sync_b = {st.sync_b[2], ext_irq_pin_b, st.sync_b[0], count_pin_1};

    //////////////////////////////////////////////////////////////////////
    // edge history moves only at a sample point
    if (tick0) begin
      next_st.prev0 = pin0;
    end
    if (tick1) begin
      next_st.prev1 = pin1;
    end
    in0 = unit_inc(nib0, run0, tick0, pin0, st.prev0, unit0_gating_bit);
    in1 = unit_inc(nib1, run1, tick1, pin1, st.prev1, unit1_gating_bit);
    // split-mode high byte: timer only, unit 1 clock and run bit
    inh = tick1 && run1;

    //////////////////////////////////////////////////////////////////////
    // unit 0 datapath
    if (split0) begin
      if (in0) begin
        b = inc8(st.l0);
        next_st.l0 = b[7:0];
        ovf0 = b[8];
      end
      if (inh) begin
        b = inc8(st.h0);
        next_st.h0 = b[7:0];
        ovf1 = b[8];
      end
    end else if (in0) begin
      s = unit_step(nib0[1:0], st.l0, st.h0);
      next_st.l0 = s[7:0];
      next_st.h0 = s[15:8];
      ovf0 = s[16];
    end
    //////////////////////////////////////////////////////////////////////
    // unit 1 datapath; mode 3 halts it and keeps its count
    next_st.baud = 1'b0;
    if (in1 && !hold1) begin
      s = unit_step(nib1[1:0], st.l1, st.h1);
      next_st.l1 = s[7:0];
      next_st.h1 = s[15:8];
      next_st.baud = s[16];
      // with unit 0 split, the overflow flag belongs to the high byte of unit 0
      if (!split0) begin
        ovf1 = s[16];
      end
    end

    // software writes; run bit writes leave counts alone
    if (mode_wr) begin
      next_st.mode = mode_wdata;
    end
    if (ctrl_wr) begin
      next_st.ctrl = ctrl_wdata;
    end
    if (count_wr[0]) begin
      next_st.l0 = count_wdata;
    end
    if (count_wr[1]) begin
      next_st.h0 = count_wdata;
    end
    if (count_wr[2]) begin
      next_st.l1 = count_wdata;
    end
    if (count_wr[3]) begin
      next_st.h1 = count_wdata;
    end
    //////////////////////////////////////////////////////////////////////
    // service clears flags, overflow wins
    next_st.ctrl[CTRL_U0_OVF_POS] = flag_next(next_st.ctrl[CTRL_U0_OVF_POS], ovf0, unit0_serviced);
    next_st.ctrl[CTRL_U1_OVF_POS] = flag_next(next_st.ctrl[CTRL_U1_OVF_POS], ovf1, unit1_serviced);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // counts, flags and pin history all start at zero
      st <= '0;
      st.mode <= MODE_RESET;
      st.ctrl <= CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////
  assign timer_mode_register = st.mode;
  assign timer_control_register = st.ctrl;
  assign unit0_low_byte = st.l0;
  assign unit0_high_byte = st.h0;
  assign unit1_low_byte = st.l1;
  assign unit1_high_byte = st.h1;
  assign unit0_irq = st.ctrl[CTRL_U0_OVF_POS];
  assign unit1_irq = st.ctrl[CTRL_U1_OVF_POS];
  assign baud_tick = st.baud;
endmodule
`default_nettype wire

// ==== hw/dual_timer_pkg.sv ====
/*
  Constants for the dual timer/counter: register bit positions, modes, reset values and rate divisors.
  Assumes nothing of its surroundings.
*/
package dual_timer_pkg;
  // mode register fields per nibble
  localparam int MODE_GATE_POS = 3;
  localparam int MODE_SRC_POS = 2;
  localparam int MODE_HI_POS = 1;
  localparam int MODE_LO_POS = 0;
  localparam int UNIT1_NIBBLE_OFS = 4;
  // control register positions
  localparam int CTRL_U1_OVF_POS = 7;
  localparam int CTRL_U1_RUN_POS = 6;
  localparam int CTRL_U0_OVF_POS = 5;
  localparam int CTRL_U0_RUN_POS = 4;
  localparam int CTRL_B_TYPE_POS = 2;
  localparam int CTRL_A_TYPE_POS = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // timer clock periods per peripheral cycle
  localparam int PER_CYCLE_TICKS = 6;
  localparam logic [4:0] PRESCALE_MAX = 5'h1F;
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_AUTO_RELOAD,
    MODE_SPLIT_HALT
  } timer_mode_t;
endpackage

// ==== hw/timer_clock_gen.sv ====
/*
  Per-unit timer clock tick generator and peripheral-cycle divider.
  Assumes sys_clk is the oscillator; produces one-cycle enables, not clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_clock_gen
  import dual_timer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clock_double_select,
  input wire logic double_speed_mode,
  output logic per_tick
);
  typedef struct packed {
    logic half;
    logic [2:0] div;
    logic tick;
  } state_t;
  state_t st;
  state_t next_st;
  logic timer_clk_en;

  always_comb begin
    next_st = st;
    next_st.half = ~st.half;
    timer_clk_en = (clock_double_select || !double_speed_mode) ? st.half : 1'b1;
    next_st.tick = 1'b0;
    if (timer_clk_en) begin
      if (st.div == 3'(PER_CYCLE_TICKS - 1)) begin
        next_st.div = 3'h0;
        next_st.tick = 1'b1;
      end else begin
        next_st.div = st.div + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign per_tick = st.tick;
endmodule
`default_nettype wire

// ==== bench/dual_timer_counter_sva.sv ====
/*
  Port-level assertion checker for dual_timer_counter.
  Assumes one sys_clk domain with synchronous active-low rst_n, bound to every instance.
*/
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_sva
  import dual_timer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic mode_wr,
  input wire logic [7:0] mode_wdata,
  input wire logic [3:0] count_wr,
  input wire logic [7:0] timer_mode_register,
  input wire logic [7:0] timer_control_register,
  input wire logic [7:0] unit0_low_byte,
  input wire logic [7:0] unit0_high_byte,
  input wire logic [7:0] unit1_low_byte,
  input wire logic [7:0] unit1_high_byte,
  input wire logic unit0_irq,
  input wire logic unit1_irq,
  input wire logic baud_tick
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic [1:0] m0 = timer_mode_register[1:0];
  wire logic [1:0] m1 = timer_mode_register[5:4];
  wire logic [7:0] tc = timer_control_register;
  ////////////////////////////////////////////////////////////////////////////////
  chk_reset_zero: assert property (disable iff (1'b0) !rst_n |=> tc == CTRL_RESET && m0 == 2'h0)
    else $error("control not cleared by reset");
  chk_irq_flags: assert property (unit0_irq == tc[CTRL_U0_OVF_POS] && unit1_irq == tc[CTRL_U1_OVF_POS])
    else $error("irq output differs from flag");
  chk_mode_store: assert property (mode_wr |=> timer_mode_register == $past(mode_wdata))
    else $error("mode write not stored");
  chk_stop_hold: assert property (!tc[4] && !$past(tc[4]) && m0 != 2'h3 && count_wr[1:0] == 2'h0
    |=> $stable(unit0_low_byte) && $stable(unit0_high_byte)) else $error("stopped unit0 counted");
  chk_halt_hold: assert property (m1 == 2'h3 && $past(m1) == 2'h3 && count_wr[3:2] == 2'h0
    |=> $stable(unit1_low_byte) && $stable(unit1_high_byte)) else $error("halted unit1 counted");
  chk_baud_pulse: assert property (baud_tick |=> !baud_tick [*5])
    else $error("baud tick too long or too close");
  chk_reload_val: assert property (m1 == 2'h2 && m0 != 2'h3 && $rose(unit1_irq) && !$past(count_wr[2])
    && !$past(count_wr[3]) |-> unit1_low_byte == unit1_high_byte) else $error("no reload from high byte");
  chk_carry_high: assert property (m0 == 2'h1 && $past(m0) == 2'h1 && $past(count_wr[1:0]) == 2'h0
    && $changed(unit0_high_byte) |-> unit0_low_byte == 8'h00 && unit0_high_byte == $past(unit0_high_byte) + 8'h01)
    else $error("high byte moved without carry");
endmodule
bind dual_timer_counter dual_timer_counter_sva chk (.*);
`default_nettype wire

// ==== bench/test_dual_timer_counter.sv ====
/*
  Self-checking bench for dual_timer_counter: strobe writes, count waits, expected values.
  Assumes the package and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module test_dual_timer_counter
  import dual_timer_pkg::*;
;
  logic sys_clk = 1'b0, rst_n = 1'b0, double_speed_mode = 1'b1;
  logic unit0_clock_double_select = 1'b1, unit1_clock_double_select = 1'b0;
  logic count_pin_0 = 1'b0, count_pin_1 = 1'b0, ext_irq_pin_a = 1'b0, ext_irq_pin_b = 1'b0;
  logic mode_wr = 1'b0, ctrl_wr = 1'b0, unit0_serviced = 1'b0, unit1_serviced = 1'b0;
  logic [3:0] count_wr = 4'h0;
  logic [7:0] mode_wdata = 8'h00, ctrl_wdata = 8'h00, count_wdata = 8'h00;
  logic [7:0] timer_mode_register, timer_control_register, unit0_low_byte, unit0_high_byte;
  logic [7:0] unit1_low_byte, unit1_high_byte;
  logic unit0_irq, unit1_irq, baud_tick;
  int n_mismatch = 0, total_checks = 0, cyc = 0, n;
  wire logic [2:0] sigs = {baud_tick, unit1_irq, unit0_irq};
  dual_timer_counter uut (.*);
  always #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // k: 0..3 count byte strobe, 4 mode, 5 control
  task automatic wr(input int k, input logic [7:0] v);
    @(negedge sys_clk);
    if (k == 4) {mode_wr, mode_wdata} = {1'b1, v};
    else if (k == 5) {ctrl_wr, ctrl_wdata} = {1'b1, v};
    else {count_wr[k], count_wdata} = {1'b1, v};
    @(negedge sys_clk);
    {mode_wr, ctrl_wr, count_wr} = 6'h00;
  endtask
  // waits for unit0 flag, unit1 flag or baud tick; n holds cycles waited
  task automatic wt(input int i);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (sigs[i] !== 1'b1 && n < 400);
    `CHK("wait", 1'b1, sigs[i])
  endtask
  task automatic pulses(input int k);
    repeat (k) begin
      repeat (15) @(negedge sys_clk);
      count_pin_0 = 1'b1;
      repeat (15) @(negedge sys_clk);
      count_pin_0 = 1'b0;
    end
    repeat (20) @(negedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    `CHK("ctrl reset", 8'h00, timer_control_register)
    wr(4, 8'h11);
    wr(1, 8'hFF);
    wr(0, 8'hFA);
    wr(5, 8'h10);
    `CHK("run keeps low", 8'hFA, unit0_low_byte)
    wt(0);
    `CHK("mode1 count", 16'h0000, {unit0_high_byte, unit0_low_byte})
    `CHK("half rate", 1'b1, n >= 60 && n <= 75)
    wr(5, 8'h20);
    unit0_serviced = 1'b1;
    @(negedge sys_clk);
    unit0_serviced = 1'b0;
    `CHK("serviced", 1'b0, unit0_irq)
    $display("test 16-bit done");
    wr(4, 8'h10);
    wr(1, 8'hFF);
    wr(0, 8'h1E);
    wr(5, 8'h10);
    wt(0);
    `CHK("mode0 count", 13'h0000, {unit0_high_byte, unit0_low_byte[4:0]})
    wr(5, 8'h00);
    $display("test 13-bit done");
    wr(4, 8'h20);
    wr(3, 8'hFD);
    wr(2, 8'hFE);
    wr(5, 8'h40);
    wt(1);
    `CHK("reload", 8'hFD, unit1_low_byte)
    `CHK("high kept", 8'hFD, unit1_high_byte)
    wt(2);
    wt(2);
    `CHK("baud period", 18, n)
    wr(3, 8'hFB);
    wt(2);
    wt(2);
    `CHK("new reload", 30, n)
    unit1_serviced = 1'b1;
    @(negedge sys_clk);
    unit1_serviced = 1'b0;
    `CHK("serviced 1", 1'b0, unit1_irq)
    double_speed_mode = 1'b0;
    wt(2);
    wt(2);
    `CHK("standard rate", 60, n)
    double_speed_mode = 1'b1;
    wr(5, 8'h00);
    $display("test auto-reload done");
    unit0_clock_double_select = 1'b0;
    wr(4, 8'h0D);
    wr(0, 8'h00);
    wr(1, 8'h00);
    wr(5, 8'h10);
    pulses(2);
    `CHK("gated off", 8'h00, unit0_low_byte)
    ext_irq_pin_a = 1'b1;
    pulses(3);
    `CHK("gated on", 8'h03, unit0_low_byte)
    wr(5, 8'h00);
    wr(4, 8'h05);
    wr(5, 8'h10);
    ext_irq_pin_a = 1'b0;
    pulses(2);
    `CHK("ungated", 8'h05, unit0_low_byte)
    wr(5, 8'h00);
    $display("test counter done");
    wr(4, 8'h33);
    wr(2, 8'h5A);
    wr(1, 8'hFE);
    wr(0, 8'hFF);
    wr(5, 8'h50);
    wt(0);
    `CHK("split low", 8'h00, unit0_low_byte)
    wt(1);
    `CHK("split high", 8'h00, unit0_high_byte)
    `CHK("unit1 held", 8'h5A, unit1_low_byte)
    $display("test split done");
    test_done();
  end
endmodule
`default_nettype wire
